// *** hdl/ccb_branch_unit.v ***
// Coprocessor condition branch decode, evaluate and delay-slot control
`timescale 1ns/10ps
`include "ccb_regs.vh"

// Contract
// RQ1: Legacy FP true-likely branch taken when selected FP condition bit is one.
// RQ2: Untaken likely branch nullifies its delay-slot instruction.
// RQ3: Target is next-instruction address plus sign-extended offset shifted left two.
// RQ4: New cop-2 branches load PC with branch address plus four plus offset.
// RQ5: New cop-2 branches decoded by opcode 010010 and sub-op 01001 or 01101.
// RQ6: Equal-zero form taken on zero condition; not-equal-zero form on non-zero.
// RQ7: Five-bit selector goes to the coprocessor-2 interface.
// RQ8: New cop-2 branches always execute, never nullify, the delay slot.
// RQ9: Release 6 mode raises reserved instruction for a CTI in a delay slot.
// RQ10: CTIs are branches, jumps, link-without-branch, returns, wait and pause.
// RQ11: Coprocessor unusable raised when cop-2 access is disabled.
// RQ12: Legacy cop-2 false branch taken on zero condition; slot executes normally.
// RQ13: Legacy forms use three-bit code plus nullify and true/false bits.
// RQ14: Short assembler form encodes code zero, tested as condition zero.
// RQ15: FP condition bits come from the FP compare, selected by the code.
// RQ16: In single-code mode condition comes from the FPU condition signal.
// RQ17: Release 6 rejects legacy FP likely; it also flags unimplemented operation (the code flags it for the true-likely form only).
// RQ18: Software keeps CTIs out of legacy delay slots.
// RQ19: Likely forms predicted taken, without touching prediction tables.
// RQ20: Coprocessor designer defines the selector meaning.
// RQ21: Evaluate in branch stage, redirect in the following stage after the slot.
module ccb_branch_unit
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Decode stage
  input wire insn_valid_i,
  input wire [31:0] insn_i,
  input wire [31:0] pc_i,
  // Configuration
  input wire rel6_mode_i,
  input wire single_cc_mode_i,
  input wire cop1_enable_i,
  input wire second_coprocessor_opcode_enable_i,
  // Coprocessor conditions
  input wire [7:0] fp_cond_codes_i,
  input wire fpu_condition_signal_i,
  input wire second_coprocessor_opcode_cond_i,
  // Coprocessor-2 selector
  output wire [4:0] second_coprocessor_opcode_cond_select_o,
  // Branch outcome
  output reg branch_decoded_o,
  output reg redirect_o,
  output reg [31:0] redirect_pc_o,
  output reg nullify_slot_o,
  output reg predict_taken_o,
  output reg predictor_update_o,
  // Exceptions
  output reg exc_cop_unusable_o,
  output reg [1:0] exc_cop_num_o,
  output reg exc_reserved_o,
  output reg exc_unimpl_op_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SLOT = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg pend_taken;
  reg pend_likely;
  reg [31:0] pend_target;

  wire [5:0] op;
  wire [4:0] rs;
  wire [2:0] cond_code_select;
  wire nullify_delay_bit;
  wire true_false_bit;
  wire [31:0] target;
  wire slot_is_cti;

  assign op = insn_i[`CCB_OP_MSB:`CCB_OP_LSB];
  assign rs = insn_i[`CCB_RS_MSB:`CCB_RS_LSB];
  assign cond_code_select = insn_i[`CCB_CC_MSB:`CCB_CC_LSB]; // RQ13 RQ14
  assign nullify_delay_bit = insn_i[`CCB_ND_BIT]; // RQ13
  assign true_false_bit = insn_i[`CCB_TF_BIT]; // RQ13
  assign second_coprocessor_opcode_cond_select_o = insn_i[`CCB_SEL_MSB:`CCB_SEL_LSB]; // RQ7 RQ20

  ccb_target_calc u_target
  (
    .pc_i(pc_i),
    .offset_i(insn_i[`CCB_OFF_MSB:`CCB_OFF_LSB]),
    .target_o(target)
  );

  ccb_cti_detect u_cti
  (
    .insn_i(insn_i),
    .is_cti_o(slot_is_cti)
  );

  // Instruction classes
  wire is_fp_legacy;
  wire is_c2_legacy;
  wire is_c2_new;
  wire fp_true_likely_branch;
  wire cop_two_false_branch;
  wire cop_two_eqz_branch;
  wire cop_two_nez_branch;

  assign is_fp_legacy = (op == `CCB_OP_COP1) && (rs == `CCB_RS_BC);
  assign is_c2_legacy = (op == `CCB_OP_SECOND_COPROCESSOR_OPCODE) && (rs == `CCB_RS_BC);
  assign cop_two_eqz_branch = (op == `CCB_OP_SECOND_COPROCESSOR_OPCODE) && (rs == `CCB_RS_EQZ); // RQ5
  assign cop_two_nez_branch = (op == `CCB_OP_SECOND_COPROCESSOR_OPCODE) && (rs == `CCB_RS_NEZ); // RQ5
  assign is_c2_new = cop_two_eqz_branch | cop_two_nez_branch;
  assign fp_true_likely_branch = is_fp_legacy && nullify_delay_bit && true_false_bit;
  assign cop_two_false_branch = is_c2_legacy && !nullify_delay_bit && !true_false_bit;

  // FP condition: selected code, or the lone condition signal in single-code mode
  reg fp_cond;
  always @*
  begin
    if (single_cc_mode_i)
      fp_cond = fpu_condition_signal_i; // RQ16
    else
      fp_cond = fp_cond_codes_i[cond_code_select]; // RQ15 RQ14
  end

  // Decode-stage evaluation
  reg dec_branch;
  reg dec_taken;
  reg dec_likely;
  reg dec_cu;
  reg [1:0] dec_cu_num;
  reg dec_ri;
  reg dec_unimpl;
  always @*
  begin
    dec_branch = 1'b0;
    dec_taken = 1'b0;
    dec_likely = 1'b0;
    dec_cu = 1'b0;
    dec_cu_num = 2'd0;
    dec_ri = 1'b0;
    dec_unimpl = 1'b0;
    if (is_fp_legacy)
    begin
      if (rel6_mode_i)
      begin
        dec_ri = 1'b1; // RQ17
        dec_unimpl = fp_true_likely_branch; // RQ17
      end
      else if (!cop1_enable_i)
      begin
        dec_cu = 1'b1;
        dec_cu_num = 2'd1;
      end
      else
      begin
        dec_branch = 1'b1;
        dec_likely = nullify_delay_bit;
        dec_taken = (fp_cond == true_false_bit); // RQ1
      end
    end
    else if (is_c2_legacy)
    begin
      if (rel6_mode_i)
        dec_ri = 1'b1; // RQ13
      else if (!second_coprocessor_opcode_enable_i)
      begin
        dec_cu = 1'b1; // RQ11
        dec_cu_num = 2'd2;
      end
      else
      begin
        dec_branch = 1'b1;
        dec_likely = nullify_delay_bit;
        dec_taken = (second_coprocessor_opcode_cond_i == true_false_bit); // RQ12
      end
    end
    else if (is_c2_new)
    begin
      if (!rel6_mode_i)
        dec_ri = 1'b1;
      else if (!second_coprocessor_opcode_enable_i)
      begin
        dec_cu = 1'b1; // RQ11
        dec_cu_num = 2'd2;
      end
      else
      begin
        dec_branch = 1'b1;
        dec_likely = 1'b0; // RQ8
        dec_taken = cop_two_nez_branch ? second_coprocessor_opcode_cond_i : !second_coprocessor_opcode_cond_i; // RQ6
      end
    end
  end

  // Next-state logic
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (insn_valid_i && dec_branch)
          next_state = ST_SLOT; // RQ21
      end
      ST_SLOT:
      begin
        if (insn_valid_i)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  wire in_slot;
  wire slot_fire;
  wire decode_fire;
  wire branch_accept;
  wire slot_trap;
  assign in_slot = (state == ST_SLOT);
  assign slot_fire = in_slot && insn_valid_i;
  // A branch standing in a delay slot is never decoded as a branch
  assign decode_fire = !in_slot && insn_valid_i;
  assign branch_accept = decode_fire && dec_branch;
  // In Release 6 mode a transfer in the slot is refused and cancels the pending redirect
  assign slot_trap = slot_fire && rel6_mode_i && slot_is_cti; // RQ9 RQ10

  // Branch waiting for its delay slot, kept apart from the output pulses
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= ST_IDLE;
      pend_taken <= 1'b0;
      pend_likely <= 1'b0;
      pend_target <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      if (branch_accept)
      begin
        pend_taken <= dec_taken;
        pend_likely <= dec_likely;
        pend_target <= target; // RQ3 RQ4
      end
    end
  end

  // Outputs: one-cycle pulses, except the target and the unit number
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      branch_decoded_o <= 1'b0;
      redirect_o <= 1'b0;
      redirect_pc_o <= 32'h00000000;
      nullify_slot_o <= 1'b0;
      predict_taken_o <= 1'b0;
      predictor_update_o <= 1'b0;
      exc_cop_unusable_o <= 1'b0;
      exc_cop_num_o <= 2'd0;
      exc_reserved_o <= 1'b0;
      exc_unimpl_op_o <= 1'b0;
    end
    else
    begin
      branch_decoded_o <= 1'b0;
      redirect_o <= 1'b0;
      nullify_slot_o <= 1'b0;
      predict_taken_o <= 1'b0;
      predictor_update_o <= 1'b0;
      exc_cop_unusable_o <= 1'b0;
      exc_reserved_o <= 1'b0;
      exc_unimpl_op_o <= 1'b0;
      if (decode_fire)
      begin
        exc_cop_unusable_o <= dec_cu; // RQ11
        exc_reserved_o <= dec_ri;
        exc_unimpl_op_o <= dec_unimpl;
        // Unit number stays until the next refused coprocessor access
        if (dec_cu)
          exc_cop_num_o <= dec_cu_num;
        if (dec_branch)
        begin
          branch_decoded_o <= 1'b1;
          predict_taken_o <= dec_likely ? 1'b1 : dec_taken; // RQ19
          predictor_update_o <= !dec_likely; // RQ19
        end
      end
      if (slot_trap)
        exc_reserved_o <= 1'b1; // RQ9 RQ18
      else if (slot_fire)
      begin
        if (pend_taken)
        begin
          redirect_o <= 1'b1; // RQ21 RQ1 RQ12
          redirect_pc_o <= pend_target;
        end
        else if (pend_likely)
          nullify_slot_o <= 1'b1; // RQ2
      end
    end
  end

endmodule

// *** hdl/ccb_cti_detect.v ***
// Classifies an instruction word as a control-transfer instruction
`timescale 1ns/10ps
`include "ccb_regs.vh"

module ccb_cti_detect
(
  // Instruction under test
  input wire [31:0] insn_i,
  // Result
  output reg is_cti_o
);

  wire [5:0] op;
  wire [4:0] rs;
  wire [4:0] rt;
  wire [5:0] fn;

  assign op = insn_i[31:26];
  assign rs = insn_i[25:21];
  assign rt = insn_i[20:16];
  assign fn = insn_i[5:0];

  // Branches, jumps, link-without-branch, exception/debug returns, wait, pause
  always @*
  begin
    is_cti_o = 1'b0; // RQ10
    if (op == `CCB_OP_J || op == `CCB_OP_JAL)
      is_cti_o = 1'b1;
    else if (op >= `CCB_OP_BEQ && op <= `CCB_OP_BGTZ)
      is_cti_o = 1'b1;
    else if (op >= `CCB_OP_BEQL && op <= `CCB_OP_BGTZL)
      is_cti_o = 1'b1;
    else if (op == `CCB_OP_POP10 || op == `CCB_OP_POP30)
      is_cti_o = 1'b1;
    else if (op == `CCB_OP_REGIMM)
      is_cti_o = 1'b1;
    else if ((op == `CCB_OP_COP1 || op == `CCB_OP_SECOND_COPROCESSOR_OPCODE) &&
             (rs == `CCB_RS_BC || rs == `CCB_RS_EQZ || rs == `CCB_RS_NEZ))
      is_cti_o = 1'b1;
    else if (op == `CCB_OP_SPECIAL && (fn == `CCB_FN_JR || fn == `CCB_FN_JALR))
      is_cti_o = 1'b1;
    else if (op == `CCB_OP_SPECIAL && fn == `CCB_FN_SLL && rs == 5'h00 && rt == 5'h00 &&
             insn_i[15:11] == 5'h00 && insn_i[10:6] == `CCB_SHAMT_PAUSE)
      is_cti_o = 1'b1;
    else if (op == `CCB_OP_COP0 && rs[4] &&
             (fn == `CCB_FN_EXCEPTION_RETURN || fn == `CCB_FN_DEBUG_RETURN || fn == `CCB_FN_WAIT))
      is_cti_o = 1'b1;
  end

endmodule

// *** hdl/ccb_target_calc.v ***
// Branch target adder: next-instruction address plus scaled, sign-extended offset
`timescale 1ns/10ps
`include "ccb_regs.vh"

module ccb_target_calc
(
  // Branch address and immediate
  input wire [31:0] pc_i,
  input wire [15:0] offset_i,
  // Target
  output wire [31:0] target_o
);

  wire [17:0] scaled;
  wire [31:0] ext;

  assign scaled = {offset_i, 2'b00};
  assign ext = {{14{scaled[17]}}, scaled};
  assign target_o = pc_i + `CCB_INSN_BYTES + ext; // RQ3 RQ4

endmodule

// *** pkg/ccb_regs.vh ***
// Encodings, field positions and constants for the coprocessor condition branch unit
`ifndef CCB_REGS_VH
`define CCB_REGS_VH

// Major opcodes (bits 31:26)
`define CCB_OP_MSB 31
`define CCB_OP_LSB 26
`define CCB_OP_COP0 6'h10
`define CCB_OP_COP1 6'h11
`define CCB_OP_SECOND_COPROCESSOR_OPCODE 6'h12
`define CCB_OP_REGIMM 6'h01
`define CCB_OP_SPECIAL 6'h00
`define CCB_OP_J 6'h02
`define CCB_OP_JAL 6'h03
`define CCB_OP_BEQ 6'h04
`define CCB_OP_BGTZ 6'h07
`define CCB_OP_BEQL 6'h14
`define CCB_OP_BGTZL 6'h17
`define CCB_OP_POP10 6'h32
`define CCB_OP_POP30 6'h3e

// Sub-opcode field (bits 25:21)
`define CCB_RS_MSB 25
`define CCB_RS_LSB 21
`define CCB_RS_BC 5'h08
`define CCB_RS_EQZ 5'h09
`define CCB_RS_NEZ 5'h0d
`define CCB_RS_CO 5'h10

// Condition selector and legacy control bits
`define CCB_SEL_MSB 20
`define CCB_SEL_LSB 16
`define CCB_CC_MSB 20
`define CCB_CC_LSB 18
`define CCB_ND_BIT 17
`define CCB_TF_BIT 16

// Immediate offset and target arithmetic
`define CCB_OFF_MSB 15
`define CCB_OFF_LSB 0
`define CCB_OFF_SHIFT 2
`define CCB_INSN_BYTES 32'h00000004

// Function codes for the delay-slot check
`define CCB_FN_JR 6'h08
`define CCB_FN_JALR 6'h09
`define CCB_FN_SLL 6'h00
`define CCB_FN_EXCEPTION_RETURN 6'h18
`define CCB_FN_DEBUG_RETURN 6'h1f
`define CCB_FN_WAIT 6'h20
`define CCB_SHAMT_PAUSE 5'h05
`define CCB_RT_NAL 5'h10

`endif

// *** sim/ccb_branch_assertions.sv ***
// Decode, outcome and exception assertions for the branch unit
`timescale 1ns/10ps
module ccb_branch_assertions
(
  // Clock, reset and inputs
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire insn_valid_i,
  input wire [31:0] insn_i,
  input wire [31:0] pc_i,
  input wire rel6_mode_i,
  input wire single_cc_mode_i,
  input wire cop1_enable_i,
  input wire second_coprocessor_opcode_enable_i,
  input wire [7:0] fp_cond_codes_i,
  input wire fpu_condition_signal_i,
  input wire second_coprocessor_opcode_cond_i,
  // Outputs
  input wire [4:0] second_coprocessor_opcode_cond_select_o,
  input wire branch_decoded_o,
  input wire redirect_o,
  input wire [31:0] redirect_pc_o,
  input wire nullify_slot_o,
  input wire predict_taken_o,
  input wire predictor_update_o,
  input wire exc_cop_unusable_o,
  input wire [1:0] exc_cop_num_o,
  input wire exc_reserved_o,
  input wire exc_unimpl_op_o
);
  wire [5:0] op = insn_i[31:26];
  wire [4:0] rs = insn_i[25:21];
  wire new_br = op == 6'h12 && (rs == 5'h09 || rs == 5'h0d);
  wire fpl = op == 6'h11 && rs == 5'h08 && insn_i[17:16] == 2'b11;
  wire c2f = op == 6'h12 && rs == 5'h08 && insn_i[17:16] == 2'b00;
  wire fp_bit = single_cc_mode_i ? fpu_condition_signal_i : fp_cond_codes_i[insn_i[20:18]];
  wire ok_new = new_br && rel6_mode_i && second_coprocessor_opcode_enable_i;
  wire ok_fpl = fpl && !rel6_mode_i && cop1_enable_i;
  wire ok_c2f = c2f && !rel6_mode_i && second_coprocessor_opcode_enable_i;
  wire take = ok_new ? (second_coprocessor_opcode_cond_i ^ (rs == 5'h09)) : ok_fpl ? fp_bit : !second_coprocessor_opcode_cond_i;
  wire [31:0] tgt = pc_i + 32'h00000004 + {{14{insn_i[15]}}, insn_i[15:0], 2'b00};
  wire slot_cti = op == 6'h02 || op == 6'h03 || op == 6'h04 || new_br;
  reg aw, t_r, n_r, fpl_r;
  reg [31:0] tg_r;
  // Track which valid instruction is a delay slot and what its branch decided
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw <= 1'b0;
      t_r <= 1'b0;
      n_r <= 1'b0;
      fpl_r <= 1'b0;
      tg_r <= 32'h00000000;
    end
    else
    begin
      fpl_r <= insn_valid_i && !aw && ok_fpl;
      if (insn_valid_i)
        aw <= !aw && (ok_new || ok_fpl || ok_c2f);
      if (insn_valid_i && !aw)
      begin
        t_r <= take;
        n_r <= ok_fpl && !fp_bit;
        tg_r <= tgt;
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_branch;
    insn_valid_i && !aw;
  endsequence
  sequence s_slot;
    insn_valid_i && aw;
  endsequence
  a_sel_pass: assert property (second_coprocessor_opcode_cond_select_o == insn_i[20:16])
    else $error("selector not passed through");
  a_new_decode: assert property (s_branch ##0 ok_new |=> branch_decoded_o && !exc_reserved_o)
    else $error("new branch not decoded");
  a_second_coprocessor_opcode_unusable: assert property (s_branch ##0 new_br && rel6_mode_i && !second_coprocessor_opcode_enable_i
    |=> exc_cop_unusable_o && exc_cop_num_o == 2'd2 && !branch_decoded_o)
    else $error("coprocessor unusable missing");
  a_cop1_unusable: assert property (s_branch ##0 fpl && !rel6_mode_i && !cop1_enable_i
    |=> exc_cop_unusable_o && exc_cop_num_o == 2'd1 && !branch_decoded_o)
    else $error("fp coprocessor unusable missing");
  a_likely_rel6: assert property (s_branch ##0 fpl && rel6_mode_i && cop1_enable_i
    |=> exc_reserved_o && exc_unimpl_op_o && !branch_decoded_o)
    else $error("likely form accepted in rel6");
  a_new_legacy: assert property (s_branch ##0 new_br && !rel6_mode_i && second_coprocessor_opcode_enable_i
    |=> exc_reserved_o && !branch_decoded_o)
    else $error("new form accepted in legacy mode");
  a_likely_predict: assert property (branch_decoded_o && fpl_r
    |-> predict_taken_o && !predictor_update_o)
    else $error("likely branch prediction wrong");
  a_slot_outcome: assert property (s_slot ##0 !(rel6_mode_i && slot_cti)
    |=> redirect_o == t_r && nullify_slot_o == n_r && (!t_r || redirect_pc_o == tg_r))
    else $error("slot outcome wrong");
  a_slot_cti: assert property (s_slot ##0 rel6_mode_i && slot_cti
    |=> exc_reserved_o && !redirect_o)
    else $error("control transfer in slot not refused");
endmodule
bind ccb_branch_unit ccb_branch_assertions u_chk (.*);

// *** sim/ccb_cop_model.sv ***
// Coprocessor 2 condition source: one flag per selector value
`timescale 1ns/10ps
module ccb_cop_model
#(
  parameter [31:0] FLAGS = 32'h00000020
)
(
  // Selector from the branch unit
  input wire [4:0] sel_i,
  // Selected condition
  output wire second_coprocessor_opcode_cond_o
);
  assign second_coprocessor_opcode_cond_o = FLAGS[sel_i];
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the coprocessor condition branch unit
`timescale 1ns/10ps
`define CHK(n, e, a) \
  begin \
    cmp_count = cmp_count + 1; \
    if ((a) !== (e)) \
    begin \
      $display("BAD %s exp %h got %h", n, e, a); \
      error_cnt = error_cnt + 1; \
    end \
  end
module testbench;
  reg ref_clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg insn_valid_i = 1'b0;
  reg [31:0] insn_i = 32'h00000000;
  reg [31:0] pc_i = 32'h00000000;
  reg rel6_mode_i = 1'b0;
  reg single_cc_mode_i = 1'b0;
  reg cop1_enable_i = 1'b1;
  reg second_coprocessor_opcode_enable_i = 1'b1;
  reg [7:0] fp_cond_codes_i = 8'h00;
  reg fpu_condition_signal_i = 1'b0;
  wire second_coprocessor_opcode_cond_i, branch_decoded_o, redirect_o, nullify_slot_o, predict_taken_o;
  wire predictor_update_o, exc_cop_unusable_o, exc_reserved_o, exc_unimpl_op_o;
  wire [4:0] second_coprocessor_opcode_cond_select_o;
  wire [31:0] redirect_pc_o;
  wire [1:0] exc_cop_num_o;
  integer error_cnt = 0;
  integer cmp_count = 0;
  integer k;
  reg dec, pt, pu, cu, ri1, ui, red, nul, ri2;
  reg [1:0] cn;
  reg [31:0] rpc;
  reg [31:0] slots [0:2];
  always #2 ref_clk_i = ~ref_clk_i;
  ccb_branch_unit DUT (.*);
  ccb_cop_model #(.FLAGS(32'h00000030)) u_cop (.sel_i(second_coprocessor_opcode_cond_select_o), .second_coprocessor_opcode_cond_o(second_coprocessor_opcode_cond_i));
  function [31:0] tgt(input [31:0] p, input [15:0] off);
    tgt = p + 32'h00000004 + {{14{off[15]}}, off, 2'b00};
  endfunction
  task cfg(input r6, input c2, input sc, input [7:0] fc, input fs);
    begin
      @(posedge ref_clk_i);
      rel6_mode_i <= r6;
      second_coprocessor_opcode_enable_i <= c2;
      single_cc_mode_i <= sc;
      fp_cond_codes_i <= fc;
      fpu_condition_signal_i <= fs;
    end
  endtask
  // Branch then its slot back to back, capturing both answers
  task pair(input [31:0] br, input [31:0] slot, input [31:0] p);
    begin
      @(posedge ref_clk_i);
      insn_valid_i <= 1'b1;
      insn_i <= br;
      pc_i <= p;
      @(posedge ref_clk_i);
      insn_i <= slot;
      pc_i <= p + 32'h00000004;
      #1;
      {dec, pt, pu, cu, cn, ri1, ui} = {branch_decoded_o, predict_taken_o,
        predictor_update_o, exc_cop_unusable_o, exc_cop_num_o, exc_reserved_o, exc_unimpl_op_o};
      @(posedge ref_clk_i);
      insn_valid_i <= 1'b0;
      #1;
      {red, rpc, nul, ri2} = {redirect_o, redirect_pc_o, nullify_slot_o, exc_reserved_o};
    end
  endtask
  task t_new;
    begin
      cfg(1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
      for (k = 0; k < 4; k = k + 1)
      begin
        pair({6'h12, k[0] ? 5'h0d : 5'h09, k[1] ? 5'd5 : 5'd6, k[0] ? 16'h8001 : 16'h7fff},
          32'h00000000, 32'h00010000);
        `CHK("new decoded", 1'b1, dec)
        `CHK("new redirect", k[0] == k[1], red)
        `CHK("new nullify", 1'b0, nul)
        if (k[0] == k[1])
          `CHK("new target", tgt(32'h00010000, k[0] ? 16'h8001 : 16'h7fff), rpc)
      end
      cfg(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
      pair({6'h12, 5'h09, 5'd6, 16'h0010}, 32'h00000000, 32'h00000100);
      `CHK("unusable", 3'b110, {cu, cn})
      `CHK("unusable redirect", 2'b00, {dec, red})
    end
  endtask
  task t_legacy;
    begin
      // Slots hold plain instructions only
      cfg(1'b0, 1'b1, 1'b0, 8'h08, 1'b0);
      for (k = 0; k < 2; k = k + 1)
      begin
        pair({6'h11, 5'h08, k[0] ? 3'd3 : 3'd2, 2'b11, 16'hfff0}, 32'h00000000, 32'h00000800);
        `CHK("likely predict", 2'b10, {pt, pu})
        `CHK("likely redirect", k[0], red)
        `CHK("likely nullify", !k[0], nul)
        if (k[0])
          `CHK("likely target", 32'h000007c4, rpc)
      end
      cfg(1'b0, 1'b1, 1'b1, 8'h00, 1'b1);
      pair({6'h11, 5'h08, 3'd0, 2'b11, 16'h0004}, 32'h00000000, 32'h00000200);
      `CHK("single cc redirect", 1'b1, red)
      pair({6'h12, 5'h08, 3'd0, 2'b00, 16'h0002}, 32'h00000000, 32'h00000300);
      `CHK("second_coprocessor_opcode false", 3'b110, {dec, red, nul})
      `CHK("second_coprocessor_opcode false target", 32'h0000030c, rpc)
      pair({6'h12, 5'h08, 3'd1, 2'b00, 16'h0002}, 32'h00000000, 32'h00000300);
      `CHK("second_coprocessor_opcode false untaken", 3'b100, {dec, red, nul})
      cfg(1'b0, 1'b1, 1'b0, 8'hff, 1'b0);
      cop1_enable_i <= 1'b0;
      pair({6'h11, 5'h08, 3'd1, 2'b11, 16'h0004}, 32'h00000000, 32'h00000600);
      `CHK("cop1 unusable", 4'b1010, {cu, cn, dec})
      `CHK("cop1 unusable slot", 2'b00, {red, nul})
      @(posedge ref_clk_i);
      cop1_enable_i <= 1'b1;
    end
  endtask
  task t_rel6;
    begin
      cfg(1'b1, 1'b1, 1'b0, 8'hff, 1'b1);
      pair({6'h11, 5'h08, 3'd1, 2'b11, 16'h0004}, 32'h00000000, 32'h00000400);
      `CHK("likely in rel6", 3'b011, {dec, ri1, ui})
      slots[0] = {6'h02, 26'h0000010};
      slots[1] = {6'h04, 26'h0000003};
      slots[2] = {6'h12, 5'h0d, 5'd5, 16'h0001};
      for (k = 0; k < 3; k = k + 1)
      begin
        pair({6'h12, 5'h09, 5'd6, 16'h0008}, slots[k], 32'h00000500);
        `CHK("slot cti", 2'b10, {ri2, red})
      end
    end
  endtask
  task wrap_up;
    begin
      if (error_cnt == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_new;
    t_legacy;
    t_rel6;
    wrap_up;
  end
endmodule
